/* File: logic/ccr_pkg.sv */
// Package of offsets, field positions, resets and carrier types for the calibration registers
package ccr_pkg;
  localparam int          ADDR_W         = 8;
  localparam int          DATA_W         = 16;
  localparam logic [7:0]  OFS_CH6_OFS_HI = 8'h28;
  localparam logic [7:0]  OFS_CH6_OFS_LO = 8'h29;
  localparam logic [7:0]  OFS_CH6_GN_HI  = 8'h2a;
  localparam logic [7:0]  OFS_CH6_GN_LO  = 8'h2b;
  localparam logic [7:0]  OFS_CH7_CHANNEL_CONFIG    = 8'h2c;
  localparam logic [7:0]  OFS_CH7_OFS_HI = 8'h2d;
  localparam logic [7:0]  OFS_CH7_OFS_LO = 8'h2e;
  localparam logic [15:0] RST_OFS_HI     = 16'h0000;
  localparam logic [15:0] RST_OFS_LO     = 16'h0000;
  localparam logic [15:0] RST_GN_HI      = 16'h8000;
  localparam logic [15:0] RST_GN_LO      = 16'h0000;
  localparam logic [15:0] RST_CFG        = 16'h0000;
  localparam logic [7:0]  RST_GN7_HI     = 8'h80;
  localparam int          LO_FIELD_MSB   = 15;
  localparam int          LO_FIELD_LSB   = 8;
  localparam int          PH_MSB         = 15;
  localparam int          PH_LSB         = 6;
  localparam int          BYP_BIT        = 2;
  localparam int          SEL_MSB        = 1;
  localparam int          SEL_LSB        = 0;
  localparam logic [15:0] MASK_LO        = 16'hff00;
  localparam logic [15:0] MASK_CFG       = 16'hffc7;
  localparam int          CORR_W         = 24;
  localparam int          GAIN_FRAC      = 23;

  typedef enum logic [1:0] {
    CCR_SEL_PINS,
    CCR_SEL_SHORT,
    CCR_SEL_TEST_POS,
    CCR_SEL_TEST_NEG
  } ccr_sel_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } ccr_bus_s;

  typedef struct packed {
    logic [9:0] phase;
    logic       dc_filter_on;
    ccr_sel_e   input_select;
  } ccr_cfg_s;
endpackage : ccr_pkg

/* File: logic/ccr_reg16.sv */
// One 16-bit software register with a reset value and a writable bit mask
`timescale 1ns/1ps
module ccr_reg16 #(
  parameter logic [15:0] RST  = 16'h0000,
  parameter logic [15:0] MASK = 16'hffff
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        we,
  input  wire logic [15:0] wdata,
  output logic      [15:0] q
);
  logic [15:0] val_ff;
  wire  [15:0] nxt_val = we ? (wdata & MASK) : val_ff;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) val_ff <= RST & MASK;
    else         val_ff <= nxt_val;
  end

  assign q = val_ff;

  a_reserved_zero: assert property (@(posedge clk) disable iff (sys_rst)
    (q & ~MASK) == 16'h0000) else $error("reserved bits not zero");
  a_write_lands: assert property (@(posedge clk) disable iff (sys_rst)
    we |=> q == ($past(wdata) & MASK)) else $error("write not stored");
endmodule // ccr_reg16

/* File: logic/ccr_top.sv */
// Channel 6/7 calibration and channel 7 configuration registers with correction datapath
`timescale 1ns/1ps
module ccr_top
  import ccr_pkg::*;
(
  input  wire logic                     clk,
  input  wire logic                     sys_rst,
  input  wire logic [ccr_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [ccr_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic      [ccr_pkg::DATA_W-1:0] reg_rdata,
  input  wire logic                     global_dc_filter_setting,
  input  wire logic [23:0]              ch6_raw,
  input  wire logic                     ch6_raw_valid,
  input  wire logic [23:0]              ch7_raw,
  input  wire logic                     ch7_raw_valid,
  output logic      [23:0]              ch6_result,
  output logic                          ch6_result_valid,
  output logic      [23:0]              ch7_result,
  output logic                          ch7_result_valid,
  output logic      [9:0]               ch7_phase_delay,
  output logic                          ch7_dc_filter_on,
  output ccr_pkg::ccr_sel_e             ch7_input_select
);
  import ccr_pkg::*;

  ccr_bus_s bus;
  assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  logic [15:0] q6_oh, q6_ol, q6_gh, q6_gl, q7_cfg, q7_oh, q7_ol;

  wire we6_oh  = bus.wr && bus.addr == OFS_CH6_OFS_HI;
  wire we6_ol  = bus.wr && bus.addr == OFS_CH6_OFS_LO;
  wire we6_gh  = bus.wr && bus.addr == OFS_CH6_GN_HI;
  wire we6_gl  = bus.wr && bus.addr == OFS_CH6_GN_LO;
  wire we7_cfg = bus.wr && bus.addr == OFS_CH7_CHANNEL_CONFIG;
  wire we7_oh  = bus.wr && bus.addr == OFS_CH7_OFS_HI;
  wire we7_ol  = bus.wr && bus.addr == OFS_CH7_OFS_LO;

  ccr_reg16 #(.RST(RST_OFS_HI), .MASK(16'hffff)) u_6oh (.clk(clk), .sys_rst(sys_rst),
    .we(we6_oh), .wdata(bus.wdata), .q(q6_oh));
  // offset low, low byte held at zero
  ccr_reg16 #(.RST(RST_OFS_LO), .MASK(MASK_LO)) u_6ol (.clk(clk), .sys_rst(sys_rst),
    .we(we6_ol), .wdata(bus.wdata), .q(q6_ol));
  ccr_reg16 #(.RST(RST_GN_HI), .MASK(16'hffff)) u_6gh (.clk(clk), .sys_rst(sys_rst),
    .we(we6_gh), .wdata(bus.wdata), .q(q6_gh));
  // gain low, low byte held at zero
  ccr_reg16 #(.RST(RST_GN_LO), .MASK(MASK_LO)) u_6gl (.clk(clk), .sys_rst(sys_rst),
    .we(we6_gl), .wdata(bus.wdata), .q(q6_gl));
  // config, reserved bits 5:3 held at zero
  ccr_reg16 #(.RST(RST_CFG), .MASK(MASK_CFG)) u_7cf (.clk(clk), .sys_rst(sys_rst),
    .we(we7_cfg), .wdata(bus.wdata), .q(q7_cfg));
  ccr_reg16 #(.RST(RST_OFS_HI), .MASK(16'hffff)) u_7oh (.clk(clk), .sys_rst(sys_rst),
    .we(we7_oh), .wdata(bus.wdata), .q(q7_oh));
  ccr_reg16 #(.RST(RST_OFS_LO), .MASK(MASK_LO)) u_7ol (.clk(clk), .sys_rst(sys_rst),
    .we(we7_ol), .wdata(bus.wdata), .q(q7_ol));

  // Read mux; unmapped addresses read zero
  logic [15:0] rd_sel;
  always_comb begin
    unique case (bus.addr)
      OFS_CH6_OFS_HI: rd_sel = q6_oh;
      OFS_CH6_OFS_LO: rd_sel = q6_ol;
      OFS_CH6_GN_HI:  rd_sel = q6_gh;
      OFS_CH6_GN_LO:  rd_sel = q6_gl;
      OFS_CH7_CHANNEL_CONFIG:    rd_sel = q7_cfg;
      OFS_CH7_OFS_HI: rd_sel = q7_oh;
      OFS_CH7_OFS_LO: rd_sel = q7_ol;
      default:        rd_sel = 16'h0000;
    endcase
  end

  logic [15:0] rdata_ff;
  wire  [15:0] nxt_rdata = bus.rd ? rd_sel : 16'h0000;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) rdata_ff <= 16'h0000;
    else         rdata_ff <= nxt_rdata;
  end
  assign reg_rdata = rdata_ff;

  wire [23:0] ofs6 = {q6_oh, q6_ol[LO_FIELD_MSB:LO_FIELD_LSB]};
  wire [23:0] ofs7 = {q7_oh, q7_ol[LO_FIELD_MSB:LO_FIELD_LSB]};
  wire [23:0] gn6 = {q6_gh, q6_gl[LO_FIELD_MSB:LO_FIELD_LSB]};
  // Channel 7 gain registers sit outside this slice; unity gain is used
  wire [23:0] gn7 = {RST_GN7_HI, 16'h0000};

  // subtract offset then scale by gain, saturating to 24 bits
  function automatic logic [23:0] ccr_correct(input logic [23:0] raw,
                                              input logic [23:0] ofs,
                                              input logic [23:0] gn);
    logic signed [24:0] diff;
    logic signed [49:0] prod;
    logic signed [49:0] shr;
    diff = $signed({raw[23], raw}) - $signed({ofs[23], ofs});
    prod = $signed({{25{diff[24]}}, diff}) * $signed({26'h0, gn});
    shr  = prod >>> GAIN_FRAC;
    if (shr > 50'sh7fffff)       ccr_correct = 24'h7fffff;
    else if (shr < -50'sh800000) ccr_correct = 24'h800000;
    else                         ccr_correct = shr[23:0];
  endfunction

  logic [23:0] res6_ff, res7_ff;
  logic        v6_ff, v7_ff;
  wire  [23:0] nxt_res6 = ch6_raw_valid ? ccr_correct(ch6_raw, ofs6, gn6) : res6_ff;
  wire  [23:0] nxt_res7 = ch7_raw_valid ? ccr_correct(ch7_raw, ofs7, gn7) : res7_ff;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      res6_ff <= 24'h000000;
      res7_ff <= 24'h000000;
      v6_ff   <= 1'b0;
      v7_ff   <= 1'b0;
    end else begin
      res6_ff <= nxt_res6;
      res7_ff <= nxt_res7;
      v6_ff   <= ch6_raw_valid;
      v7_ff   <= ch7_raw_valid;
    end
  end
  assign ch6_result       = res6_ff;
  assign ch7_result       = res7_ff;
  assign ch6_result_valid = v6_ff;
  assign ch7_result_valid = v7_ff;

  ccr_cfg_s cfg7;
  assign cfg7.phase        = q7_cfg[PH_MSB:PH_LSB];
  // bypass wins, else follow global setting
  assign cfg7.dc_filter_on = ~q7_cfg[BYP_BIT] & global_dc_filter_setting;
  assign cfg7.input_select = ccr_sel_e'(q7_cfg[SEL_MSB:SEL_LSB]);
  assign ch7_phase_delay   = cfg7.phase;
  assign ch7_dc_filter_on  = cfg7.dc_filter_on;
  assign ch7_input_select  = cfg7.input_select;

  a_read_latency: assert property (@(posedge clk) disable iff (sys_rst)
    bus.rd && bus.addr == OFS_CH6_GN_HI |=> reg_rdata == $past(q6_gh))
    else $error("read data wrong");
  a_offset_low_rd: assert property (@(posedge clk) disable iff (sys_rst)
    bus.rd && bus.addr == OFS_CH6_OFS_LO |=> reg_rdata[7:0] == 8'h00)
    else $error("offset low byte not zero");
  a_gain_low_rd: assert property (@(posedge clk) disable iff (sys_rst)
    bus.rd && bus.addr == OFS_CH6_GN_LO |=> reg_rdata[7:0] == 8'h00)
    else $error("gain low byte not zero");
  a_offset_assembly: assert property (@(posedge clk) disable iff (sys_rst)
    we7_oh ##1 we7_ol |=> ofs7 == {$past(bus.wdata, 2), $past(bus.wdata[15:8])})
    else $error("offset assembly wrong");
  a_gain_reset: assert property (@(posedge clk)
    $fell(sys_rst) |-> gn6 == 24'h800000 && ofs6 == 24'h000000)
    else $error("reset values wrong");
  a_phase_field: assert property (@(posedge clk) disable iff (sys_rst)
    we7_cfg |=> ch7_phase_delay == $past(bus.wdata[15:6]))
    else $error("phase field wrong");
  a_dc_bypass: assert property (@(posedge clk) disable iff (sys_rst)
    q7_cfg[2] |-> !ch7_dc_filter_on)
    else $error("bypass ignored");
  a_dc_follow: assert property (@(posedge clk) disable iff (sys_rst)
    !q7_cfg[2] |-> ch7_dc_filter_on == global_dc_filter_setting)
    else $error("global setting not followed");
  a_mux_select: assert property (@(posedge clk) disable iff (sys_rst)
    we7_cfg |=> ch7_input_select == ccr_sel_e'($past(bus.wdata[1:0])))
    else $error("input select wrong");
  a_unity_pass: assert property (@(posedge clk) disable iff (sys_rst)
    ch6_raw_valid && ofs6 == 24'h0 && gn6 == 24'h800000 |=> ch6_result == $past(ch6_raw))
    else $error("unity correction changed data");

  c_cfg_write: cover property (@(posedge clk) we7_cfg ##1 bus.rd && bus.addr == OFS_CH7_CHANNEL_CONFIG);
  c_bypass_on: cover property (@(posedge clk) $rose(q7_cfg[2]));
  c_test_neg:  cover property (@(posedge clk) ch7_input_select == CCR_SEL_TEST_NEG);
  c_corrected: cover property (@(posedge clk) ch6_raw_valid && ofs6 != 24'h0);
endmodule // ccr_top

/* File: sim/ccr_top_tb_top.sv */
// Self-checking bench for the channel 6/7 calibration and configuration registers
`timescale 1ns/1ps
module ccr_top_tb_top;
  import ccr_pkg::*;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  ccr_bus_s    bus = '0;
  logic [15:0] reg_rdata;
  logic        gdc = 1'b0;
  logic [23:0] raw6 = '0, raw7 = '0, res6, res7;
  logic        rv6 = 1'b0, rv7 = 1'b0, ov6, ov7, dc_on;
  logic [9:0]  phase;
  ccr_sel_e    sel;
  int          err_count = 0, checks = 0;
  logic [15:0] rnd = 16'h004c;
  logic [7:0]  adr [7] = '{8'h28, 8'h29, 8'h2a, 8'h2b, 8'h2c, 8'h2d, 8'h2e};
  logic [15:0] rst [7] = '{RST_OFS_HI, RST_OFS_LO, RST_GN_HI, RST_GN_LO, RST_CFG, 16'h0, 16'h0};
  logic [15:0] msk [7] = '{16'hffff, MASK_LO, 16'hffff, MASK_LO, MASK_CFG, 16'hffff, MASK_LO};
  logic [15:0] o6h, o6l, g6h, g6l, o7h, o7l, cfg, nxr;

  ccr_top i_dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(bus.addr), .reg_wdata(bus.wdata),
    .reg_wr(bus.wr), .reg_rd(bus.rd), .reg_rdata(reg_rdata), .global_dc_filter_setting(gdc),
    .ch6_raw(raw6), .ch6_raw_valid(rv6), .ch7_raw(raw7), .ch7_raw_valid(rv7),
    .ch6_result(res6), .ch6_result_valid(ov6), .ch7_result(res7), .ch7_result_valid(ov7),
    .ch7_phase_delay(phase), .ch7_dc_filter_on(dc_on), .ch7_input_select(sel));

  always #25 clk = ~clk;

  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Offset subtracted, unsigned gain with 23 fraction bits, saturated to signed 24 bits
  function automatic logic [23:0] corr(input logic [23:0] x, o, g);
    longint p;
    p = (longint'($signed(x)) - longint'($signed(o))) * longint'({1'b0, g});
    p = p >>> 23;
    if (p > 64'sd8388607) p = 64'sd8388607;
    if (p < -64'sd8388608) p = -64'sd8388608;
    return p[23:0];
  endfunction

  task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
    #1;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk);
    bus <= '{addr: a, wdata: 16'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 chk("read data", {8'h0, exp}, {8'h0, reg_rdata});
    @(posedge clk);
    #1 chk("idle read data", 24'h0, {8'h0, reg_rdata});
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #200us;
    err_count++;
    finish_test();
  end

  initial begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 7; i++) rd_chk(adr[i], rst[i]);
    rd_chk(8'h30, 16'h0);
    for (int i = 0; i < 7; i++) begin
      rnd = nxt(rnd);
      wr(adr[i], rnd);
      wr(8'h2f, ~rnd);
      rd_chk(adr[i], rnd & msk[i]);
    end
    for (int i = 0; i < 16; i++) begin
      rnd = nxt(rnd);
      cfg = {rnd[9:0], 3'b111, i[2:0]};
      wr(8'h2c, cfg);
      @(posedge clk) gdc <= i[3];
      #1 chk("phase", {14'h0, cfg[15:6]}, {14'h0, phase});
      chk("dc filter", {23'h0, i[3] & ~i[2]}, {23'h0, dc_on});
      chk("input select", {22'h0, i[1:0]}, {22'h0, sel});
    end
    for (int i = 0; i < 6; i++) begin
      rnd = nxt(rnd); o6h = rnd | 16'h8000; rnd = nxt(rnd); o6l = rnd;
      rnd = nxt(rnd); g6h = (i == 0) ? 16'hffff : rnd; rnd = nxt(rnd); g6l = rnd;
      rnd = nxt(rnd); o7h = rnd; rnd = nxt(rnd); o7l = rnd;
      wr(8'h28, o6h); wr(8'h29, o6l); wr(8'h2a, g6h);
      wr(8'h2b, g6l); wr(8'h2d, o7h); wr(8'h2e, o7l);
      rnd = nxt(rnd);
      nxr = nxt(rnd);
      @(posedge clk) begin
        raw6 <= (i == 0) ? 24'h7ffffe : {1'b0, rnd, nxr[6:0]};
        raw7 <= {nxr, rnd[7:0]};
        rv6 <= 1'b1;
        rv7 <= 1'b1;
      end
      @(posedge clk) begin
        rv6 <= 1'b0;
        rv7 <= 1'b0;
      end
      #1 chk("ch6 valid", 24'h1, {23'h0, ov6});
      chk("ch7 valid", 24'h1, {23'h0, ov7});
      chk("ch6 result", corr(raw6, {o6h, o6l[15:8]}, {g6h, g6l[15:8]}), res6);
      chk("ch7 result", corr(raw7, {o7h, o7l[15:8]}, 24'h800000), res7);
      @(posedge clk);
      #1 chk("ch6 valid drop", 24'h0, {23'h0, ov6});
      chk("ch6 result hold", corr(raw6, {o6h, o6l[15:8]}, {g6h, g6l[15:8]}), res6);
      chk("ch7 valid drop", 24'h0, {23'h0, ov7});
    end
    // Back-to-back writes to the channel 7 offset pair, then a read at once
    @(posedge clk) bus <= '{addr: 8'h2d, wdata: 16'h1234, wr: 1'b1, rd: 1'b0};
    @(posedge clk) bus <= '{addr: 8'h2e, wdata: 16'h56ff, wr: 1'b1, rd: 1'b0};
    @(posedge clk) bus <= '{addr: 8'h2e, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk) bus.rd <= 1'b0;
    #1 chk("back to back read", 24'h005600, {8'h0, reg_rdata});
    finish_test();
  end
endmodule // ccr_top_tb_top
